// ---- dmc_map.svh ----
`ifndef DMC_MAP_SVH
`define DMC_MAP_SVH
// apb register byte offsets
`define DMC_CFG_ADDR        12'h000
`define DMC_STRAP_ADDR      12'h004
`define DMC_STATUS_ADDR     12'h008
`define DMC_CYCLE_ADDR      12'h00c
// cfg register field positions
`define DMC_CFG_WIDTH_BIT   0
`define DMC_CFG_FCSEL_BIT   1
`define DMC_CFG_PINFN_BIT   2
// cfg reset value: 32-bit bus, peripheral connector, pin function 0
`define DMC_CFG_RST         32'h0000_0002
// strap fields on the display memory data bus
`define DMC_STRAP_TYPE_HI   3
`define DMC_STRAP_TYPE_LO   2
`define DMC_STRAP_SIZE_HI   7
`define DMC_STRAP_SIZE_LO   5
// memory size codes
`define DMC_SIZE_4MB        3'b000
`define DMC_SIZE_2MB        3'b100
`define DMC_SIZE_1MB        3'b110
// dram type codes (1-cycle edo is 00)
`define DMC_TYPE_EDO1       2'b00
`define DMC_TYPE_FPM        2'b11
// memory cycle length in clocks
`define DMC_CYC_LEN         4'h4
// bit of the 22-bit byte address that picks the upper 2 MBytes
`define DMC_HI_ADDR_BIT     21
`endif

// ---- dmc_pkg.sv ----
`default_nettype none
package dmc_pkg;
   typedef enum logic [1:0] {DMC_FPM, DMC_EDO, DMC_EDO1} dmc_dram_t;
   typedef enum logic [1:0] {DMC_1MB, DMC_2MB, DMC_4MB} dmc_size_t;
   typedef struct packed {
      logic        wide;
      logic        legacy_fc;
      logic        pin_fn;
      logic        pci;
      dmc_dram_t   dram;
      dmc_size_t   size;
   } dmc_cfg_t;
   typedef struct packed {
      logic        ras_n;
      logic        ras_up_n;
      logic        oe_n;
      logic        oe2_n;
   } dmc_ctl_t;
endpackage
`default_nettype wire

// ---- dmc_pin_mux.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dmc_map.svh"
module dmc_pin_mux
   import dmc_pkg::*;
(
   input  wire dmc_cfg_t cfg,
   input  wire logic     cyc,
   input  wire logic     hi_half,
   input  wire logic     oe_act,
   output var dmc_ctl_t  ctl,
   output logic          shared_pin_n,
   output logic          bus64
);
   wire  fc_on   = cfg.legacy_fc;
   // width bit only widens for 2+ MBytes and never with the legacy connector
   assign bus64 = cfg.wide && cfg.size != DMC_1MB && !fc_on;
   wire  four   = cfg.size == DMC_4MB && cfg.pci;
   wire  lo_sel = !four || !hi_half;
   wire  up_sel = four && hi_half;
   assign ctl.ras_n    = !(cyc && lo_sel);
   assign ctl.ras_up_n = !(cyc && up_sel);
   assign ctl.oe_n     = !(cyc && oe_act);
   // second mbyte enable; held high when the bus is forced to 32 bits
   assign ctl.oe2_n    = !(cyc && oe_act && bus64);
   // shared pin: upper strobe only on pci with function 1
   assign shared_pin_n = !cfg.pci       ? ctl.oe_n :
                         cfg.pin_fn     ? ctl.ras_up_n :
                         cfg.dram == DMC_FPM ? ctl.oe_n : ctl.oe2_n;
endmodule
`default_nettype wire

// ---- dmc_strap.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dmc_map.svh"
module dmc_strap
   import dmc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [31:0] straps,
   output var dmc_dram_t    dram,
   output var dmc_size_t    size,
   output logic [7:0]       raw
);
   logic [7:0] raw_q;
   // caught while reset is held, so the last value before release stays
   always_ff @(posedge clk) begin
      if (rst) begin
         raw_q <= straps[7:0];
      end
   end
   wire [1:0] t = raw_q[`DMC_STRAP_TYPE_HI:`DMC_STRAP_TYPE_LO];
   wire [2:0] s = raw_q[`DMC_STRAP_SIZE_HI:`DMC_STRAP_SIZE_LO];
   assign raw  = raw_q;
   assign dram = t == `DMC_TYPE_FPM ? DMC_FPM : t == `DMC_TYPE_EDO1 ? DMC_EDO1 : DMC_EDO;
   assign size = s == `DMC_SIZE_4MB ? DMC_4MB : s == `DMC_SIZE_2MB ? DMC_2MB : DMC_1MB;
endmodule
`default_nettype wire

// ---- dmc_ctrl.sv ----
// Function
// - fast page, edo and 1-cycle edo; type taken from data bus straps
// - parts organised 256Kx4, 256Kx8 or 256Kx16 all accepted
// - one MByte always runs the data bus 32 bits wide
// - connector bit: 0 legacy multiplexed connector, 1 peripheral bus connector
// - two MBytes allow 64 bits unless legacy connector enabled
// - forced 32-bit bus holds the second MByte output enable high
// - edo, pci, function 0: shared pin carries second output enable
// - edo, 2MB, legacy connector: second enable held high all cycle
// - pci with function 1: shared pin drives the upper row strobe
// - vl-bus has no upper row strobe; memory capped at 2MB
// - first enable may drive both MBytes; 4MB expansion pci only
// - width bit 0 gives 32 bits; 1 gives 64 for 2MB or more on the peripheral connector
`timescale 1ns/100ps
`default_nettype none
`include "dmc_map.svh"
module dmc_ctrl
   import dmc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [31:0] display_memory_data_bus,
   input  wire logic        pci_bus,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        mem_req,
   input  wire logic        mem_read,
   input  wire logic [21:0] mem_addr,
   output logic             mem_ack,
   output logic             row_strobe_n,
   output logic             first_output_enable_n,
   output logic             shared_pin_n,
   output logic             bus64
);
   ////////////////////////////////////////////////////////////////
   logic [31:0] cfg_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic [31:0] cyc_cnt_q;
   dmc_dram_t   dram;
   dmc_size_t   size_raw;
   logic [7:0]  strap_raw;

   dmc_strap u_strap (
      .clk    (clk),
      .rst    (rst),
      .straps (display_memory_data_bus),
      .dram   (dram),
      .size   (size_raw),
      .raw    (strap_raw)
   );

   ////////////////////////////////////////////////////////////////
   // cycle sequencer
   typedef enum logic [1:0] {ST_IDLE, ST_ACT, ST_DONE} dmc_seq_t;
   dmc_seq_t   st_q;
   dmc_seq_t   st_d;
   logic [3:0] cnt_q;
   logic       read_q;
   logic       hi_q;
   wire        last = cnt_q == `DMC_CYC_LEN - 4'h1;
   // a request still high while the ack stands belongs to the cycle just ended
   wire        take = st_q == ST_IDLE && mem_req && !mem_ack;

   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: if (take) st_d = ST_ACT;
         ST_ACT:  if (last) st_d = ST_DONE;
         ST_DONE: st_d = ST_IDLE;
         default: st_d = ST_IDLE;
      endcase
   end

   // organisation does not change sequencing, only chip count
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q   <= ST_IDLE;
         cnt_q  <= 4'h0;
         read_q <= 1'b0;
         hi_q   <= 1'b0;
      end else begin
         st_q  <= st_d;
         cnt_q <= (st_q == ST_ACT) ? cnt_q + 4'h1 : 4'h0;
         if (take) begin
            read_q <= mem_read;
            hi_q   <= mem_addr[`DMC_HI_ADDR_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // vl-bus caps at two MBytes
   wire dmc_size_t size = (!pci_bus && size_raw == DMC_4MB) ? DMC_2MB : size_raw;
   dmc_cfg_t cfg;
   assign cfg.wide      = cfg_q[`DMC_CFG_WIDTH_BIT];
   assign cfg.legacy_fc = !cfg_q[`DMC_CFG_FCSEL_BIT];
   assign cfg.pin_fn    = cfg_q[`DMC_CFG_PINFN_BIT];
   assign cfg.pci       = pci_bus;
   assign cfg.dram      = dram;
   assign cfg.size      = size;

   wire cyc = st_q == ST_ACT;
   // fast page holds oe off for the first clock only, then drives it; edo drives it the whole cycle
   wire oe_act = read_q && (dram != DMC_FPM || cnt_q >= 4'h1);
   dmc_ctl_t ctl;
   logic     shared_d;
   logic     bus64_d;

   dmc_pin_mux u_mux (
      .cfg          (cfg),
      .cyc          (cyc),
      .hi_half      (hi_q),
      .oe_act       (oe_act),
      .ctl          (ctl),
      .shared_pin_n (shared_d),
      .bus64        (bus64_d)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         row_strobe_n          <= 1'b1;
         first_output_enable_n <= 1'b1;
         shared_pin_n          <= 1'b1;
         bus64                 <= 1'b0;
         mem_ack               <= 1'b0;
      end else begin
         row_strobe_n          <= ctl.ras_n;
         first_output_enable_n <= ctl.oe_n;
         shared_pin_n          <= shared_d;
         bus64                 <= bus64_d;
         mem_ack               <= st_q == ST_DONE;
      end
   end

   ////////////////////////////////////////////////////////////////
   // apb slave, one wait state: pready rises one cycle into the access phase
   wire acc      = psel && penable && !pready_q;
   // writes land at the edge where the master sees pready
   wire done     = psel && penable && pready_q;
   wire a_cfg    = paddr == `DMC_CFG_ADDR;
   wire a_strap  = paddr == `DMC_STRAP_ADDR;
   wire a_stat   = paddr == `DMC_STATUS_ADDR;
   wire a_cyc    = paddr == `DMC_CYCLE_ADDR;
   wire mapped   = a_cfg || a_strap || a_stat || a_cyc;
   wire [31:0] status = {26'h000_0000, cfg.legacy_fc, bus64_d, size, dram};
   wire [31:0] rd_mux = a_cfg   ? cfg_q :
                        a_strap ? {24'h00_0000, strap_raw} :
                        a_stat  ? status :
                        a_cyc   ? cyc_cnt_q : 32'h0000_0000;

   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_q     <= `DMC_CFG_RST;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         cyc_cnt_q <= 32'h0000_0000;
      end else begin
         pready_q  <= acc;
         pslverr_q <= acc && !mapped;
         prdata_q  <= (acc && !pwrite) ? rd_mux : 32'h0000_0000;
         // only low three bits are writable
         if (done && pwrite && a_cfg) cfg_q <= {29'h0000_0000, pwdata[2:0]};
         if (mem_ack) cyc_cnt_q <= cyc_cnt_q + 32'h0000_0001;
      end
   end

   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign prdata  = prdata_q;
endmodule
`default_nettype wire

// ---- dmc_ctrl_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module dmc_ctrl_properties (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [31:0] display_memory_data_bus,
   input wire logic        pci_bus,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        mem_req,
   input wire logic        mem_ack,
   input wire logic        row_strobe_n,
   input wire logic        first_output_enable_n,
   input wire logic        shared_pin_n,
   input wire logic        bus64
);
   logic [7:0] strap_q;
   logic [2:0] cfg_q;
   wire        fpm = strap_q[3:2] == 2'b11;
   // cfg mirror follows completed writes only
   always_ff @(posedge clk) begin
      if (rst) begin
         strap_q <= display_memory_data_bus[7:0];
         cfg_q   <= 3'b010;
      end else if (psel && penable && pready && pwrite && paddr == 12'h000) begin
         cfg_q <= pwdata[2:0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_ack_delay: assert property ($rose(mem_req) |-> ##6 mem_ack)
      else $error("memory ack not six cycles after request");
   a_row_width: assert property ($fell(row_strobe_n) |-> !row_strobe_n [*4] ##1 row_strobe_n)
      else $error("row strobe not low for four cycles");
   a_narrow_1mb: assert property (mem_req && strap_q[7:5] == 3'b110 |-> !bus64)
      else $error("wide bus with one MByte");
   a_wide_cause: assert property (mem_req && bus64 |-> cfg_q[0] && cfg_q[1])
      else $error("wide bus without width bit or with legacy connector");
   a_vl_first: assert property (!pci_bus |-> shared_pin_n == first_output_enable_n)
      else $error("shared pin not first enable on local bus");
   a_fpm_share: assert property (pci_bus && !cfg_q[2] && fpm |-> shared_pin_n == first_output_enable_n)
      else $error("shared pin not first enable with fast page");
   a_upper_split: assert property (pci_bus && cfg_q[2] |-> row_strobe_n || shared_pin_n)
      else $error("both row strobes low");
   a_narrow_quiet: assert property (pci_bus && !cfg_q[2] && !fpm && !(cfg_q[0] && cfg_q[1]) |-> shared_pin_n)
      else $error("second enable active on narrow bus");
endmodule
bind dmc_ctrl dmc_ctrl_properties dmc_ctrl_properties_inst (.clk, .rst, .display_memory_data_bus, .pci_bus,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .mem_req, .mem_ack, .row_strobe_n,
   .first_output_enable_n, .shared_pin_n, .bus64);
`default_nettype wire

// ---- dmc_dram_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module dmc_dram_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [7:0] strap,
   input  wire logic       row_strobe_n,
   input  wire logic       first_output_enable_n,
   input  wire logic       shared_pin_n,
   output logic [31:0]     display_memory_data_bus
);
   logic [7:0] cnt_q;
   always_ff @(posedge clk) begin
      cnt_q <= rst ? 8'h00 : cnt_q + 8'h01;
   end
   // at most eight parts; shared pin reaches only upper banks
   wire sel   = !row_strobe_n || !shared_pin_n;
   wire drive = sel && (!first_output_enable_n || !shared_pin_n);
   // released bus shows a moving pattern, so stale data never looks valid
   assign display_memory_data_bus = rst ? {24'h00_0000, strap} : drive ? 32'ha5a5_c3c3 : {4{cnt_q}};
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
   import dmc_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, pci_bus = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        mem_req = 1'b0, mem_read = 1'b1, pready, pslverr, mem_ack, bus64;
   logic        row_strobe_n, first_output_enable_n, shared_pin_n;
   logic [11:0] paddr = 12'h000;
   logic [21:0] mem_addr = 22'h00_0000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, display_memory_data_bus;
   logic [7:0]  strap = 8'h04;
   int          num_errors = 0, n_compared = 0;
   dmc_ctrl dmc_ctrl_inst (.clk, .rst, .display_memory_data_bus, .pci_bus, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_read, .mem_addr, .mem_ack,
      .row_strobe_n, .first_output_enable_n, .shared_pin_n, .bus64);
   dmc_dram_model dmc_dram_model_inst (.clk, .rst, .strap, .row_strobe_n, .first_output_enable_n,
      .shared_pin_n, .display_memory_data_bus);
   initial forever #10 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic guard(input logic ok);
      if (ok !== 1'b1) begin
         num_errors++;
         $display("ERROR %0t: wait timed out", $time);
         conclude();
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x,
      input logic e);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      guard(pready);
      chk({31'h0, pslverr}, {31'h0, e});
      if (!w) chk(prdata, x);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic mem_cycle(input logic [21:0] a, input logic b, input int nr, input int ns, input int no);
      int k, r, s, o;
      k = 0;
      r = 0;
      s = 0;
      o = 0;
      @(posedge clk);
      mem_req <= 1'b1;
      mem_addr <= a;
      do begin
         @(negedge clk);
         k++;
         r += (row_strobe_n === 1'b0);
         s += (shared_pin_n === 1'b0);
         o += (first_output_enable_n === 1'b0);
         if (k == 3) chk({31'h0, bus64}, {31'h0, b});
      end while (mem_ack !== 1'b1 && k < 20);
      guard(mem_ack);
      @(posedge clk);
      mem_req <= 1'b0;
      chk(r, nr);
      chk(s, ns);
      chk(o, no);
   endtask
   task automatic reset_dut(input logic [7:0] s, input logic p);
      @(posedge clk);
      rst <= 1'b1;
      strap <= s;
      pci_bus <= p;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
   endtask
   task automatic run_case(input logic [7:0] s, input logic p, input logic [2:0] c, input logic [21:0] a,
      input logic b, input int nr, input int ns, input int no);
      reset_dut(s, p);
      apb(1'b1, 12'h000, {29'h0, c}, 32'h0000_0000, 1'b0);
      mem_cycle(a, b, nr, ns, no);
   endtask
   initial begin
      reset_dut(8'h04, 1'b1);
      apb(1'b0, 12'h000, 32'h0000_0000, 32'h0000_0002, 1'b0);
      apb(1'b0, 12'h008, 32'h0000_0000, 32'h0000_0009, 1'b0);
      apb(1'b1, 12'h010, 32'h0000_0007, 32'h0000_0000, 1'b1);
      apb(1'b0, 12'h010, 32'h0000_0000, 32'h0000_0000, 1'b1);
      run_case(8'h04, 1'b1, 3'h7, 22'h00_0000, 1'b1, 4, 0, 4);
      mem_cycle(22'h20_0000, 1'b1, 0, 4, 4);
      apb(1'b0, 12'h00c, 32'h0000_0000, 32'h0000_0002, 1'b0);
      run_case(8'h80, 1'b1, 3'h3, 22'h00_0000, 1'b1, 4, 4, 4);
      apb(1'b1, 12'h004, 32'hffff_ffff, 32'h0000_0000, 1'b0);
      apb(1'b0, 12'h004, 32'h0000_0000, 32'h0000_0080, 1'b0);
      apb(1'b0, 12'h008, 32'h0000_0000, 32'h0000_0016, 1'b0);
      run_case(8'h84, 1'b1, 3'h0, 22'h00_0000, 1'b0, 4, 0, 4);
      apb(1'b0, 12'h008, 32'h0000_0000, 32'h0000_0025, 1'b0);
      run_case(8'h8c, 1'b1, 3'h3, 22'h00_0000, 1'b1, 4, 3, 3);
      run_case(8'hc4, 1'b0, 3'h3, 22'h00_0000, 1'b0, 4, 4, 4);
      run_case(8'h0c, 1'b0, 3'h3, 22'h20_0000, 1'b1, 4, 3, 3);
      run_case(8'hcc, 1'b1, 3'h3, 22'h00_0000, 1'b0, 4, 3, 3);
      mem_read <= 1'b0;
      mem_cycle(22'h00_0000, 1'b0, 4, 0, 0);
      conclude();
   end
endmodule
`default_nettype wire
